// file: include/acc_alu_pkg.sv
// constants for the accumulator add and logic slice
// assumes a ten-bit instruction word and four-bit data path
package acc_alu_pkg;
    localparam int         INSN_W       = 10;
    localparam int         NIB_W        = 4;
    localparam int         IMM_W        = 4;
    localparam int         OPC_LSB      = 4;
    localparam logic [5:0] OP_ADD_IMM   = 6'h06;
    localparam logic [9:0] OP_ADD_MEM   = 10'h00A;
    localparam logic [9:0] OP_ADD_MEMC  = 10'h00B;
    localparam logic [9:0] OP_AND_MEM   = 10'h018;
    localparam logic [3:0] ACC_RESET    = 4'h0;
    localparam logic       CARRY_RESET  = 1'b0;

    typedef enum {
        OP_NONE,
        OP_ADDI,
        OP_ADDM,
        OP_ADDMC,
        OP_ANDM
    } op_type;
endpackage : acc_alu_pkg

// file: verilog/acc_alu.sv
// accumulator slice: add immediate, add memory, add memory with carry, and memory
// assumes insn_valid marks one instruction per cycle and mem_nibble is the memory at
// pointer for that same cycle; skip sequencing lives outside
//
// How it works
// - add-immediate is code 000110 plus a four-bit value, added in one cycle
// - add-immediate keeps carry and writes the truncated four-bit sum
// - add-immediate asks a skip of the next instruction when no overflow
// - add-memory, code 0000001010, adds memory at pointer into the accumulator, no skip
// - add-memory leaves the carry flag as it was
// - add-memory-with-carry, code 0000001011, adds memory at pointer and carry
// - and-memory, code 0000011000, ands memory into accumulator, carry kept, no skip
`timescale 1ns/10ps
module acc_alu
    import acc_alu_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // instruction in
    input  wire logic              insn_valid,
    input  wire logic [INSN_W-1:0] insn_word,
    input  wire logic [NIB_W-1:0]  mem_nibble,
    // state out
    output logic      [NIB_W-1:0]  accumulator,
    output logic                   carry_flag,
    output logic                   skip_next
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic op_type decode(input logic [INSN_W-1:0] w);
        op_type r;
        r = OP_NONE;
        if (w[INSN_W-1:OPC_LSB] == OP_ADD_IMM)
            r = OP_ADDI;
        else if (w == OP_ADD_MEM)
            r = OP_ADDM;
        else if (w == OP_ADD_MEMC)
            r = OP_ADDMC;
        else if (w == OP_AND_MEM)
            r = OP_ANDM;
        return r;
    endfunction : decode

    // one adder shape for all three sums, so the carry out always sits at bit NIB_W
    function automatic logic [NIB_W:0] add_nibbles(
        input logic [NIB_W-1:0] a,
        input logic [NIB_W-1:0] b,
        input logic             c
    );
        return {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, c};
    endfunction : add_nibbles

    op_type           op;
    logic [NIB_W-1:0] imm;
    logic [NIB_W-1:0] and_bits;
    logic [NIB_W:0]   sum_imm;
    logic [NIB_W:0]   sum_mem;
    logic [NIB_W:0]   sum_memc;
    logic [NIB_W-1:0] acc_q, acc_d;
    logic             cy_q, cy_d;
    logic             skip_q, skip_d;

    assign op  = insn_valid ? decode(insn_word) : OP_NONE;
    assign imm = insn_word[IMM_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // the decoder splits the word into a six-bit opcode and the immediate field

    if (INSN_W - OPC_LSB != $bits(OP_ADD_IMM)) begin : g_bad_opcode_split
        $error("opcode field does not fill the upper word bits");
    end
    if (IMM_W != NIB_W) begin : g_bad_imm_width
        $error("immediate field must match the data width");
    end
    if (OPC_LSB != IMM_W) begin : g_bad_imm_place
        $error("immediate field must sit at the bottom of the word");
    end
    if ($bits(OP_ADD_MEM) != INSN_W) begin : g_bad_code_width
        $error("full codes must be as wide as the word");
    end

    ////////////////////////////////////////////////////////////////////////////
    // operands
    // all three sums run every cycle; one shared adder would need a mux in the carry path

    for (genvar b = 0; b < NIB_W; b++) begin : g_and_bit
        assign and_bits[b] = acc_q[b] & mem_nibble[b];
    end

    assign sum_imm  = add_nibbles(acc_q, imm, 1'b0);
    assign sum_mem  = add_nibbles(acc_q, mem_nibble, 1'b0);
    assign sum_memc = add_nibbles(acc_q, mem_nibble, cy_q);

    ////////////////////////////////////////////////////////////////////////////
    // accumulator and carry

    always_comb begin
        acc_d = acc_q;
        cy_d  = cy_q;
        unique case (op)
            OP_ADDI: begin
                acc_d = sum_imm[NIB_W-1:0];
            end
            OP_ADDM: begin
                acc_d = sum_mem[NIB_W-1:0];
            end
            OP_ADDMC: begin
                acc_d = sum_memc[NIB_W-1:0];
                cy_d  = sum_memc[NIB_W];
            end
            OP_ANDM: begin
                acc_d = and_bits;
            end
            OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_q <= ACC_RESET;
            cy_q  <= CARRY_RESET;
        end else begin
            acc_q <= acc_d;
            cy_q  <= cy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // skip request
    // only reported here; the sequencer outside drops the next word

    always_comb begin
        skip_d = (op == OP_ADDI) && !sum_imm[NIB_W];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    assign accumulator = acc_q;
    assign carry_flag  = cy_q;
    assign skip_next   = skip_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_addi_sum: assert property (op == OP_ADDI |=> acc_q ==
        4'($past(acc_q) + $past(insn_word[3:0]))) else $error("addi sum wrong");
    a_addi_carry: assert property (op == OP_ADDI |=> $stable(cy_q))
        else $error("addi changed carry");
    a_addi_skip: assert property (op == OP_ADDI |=> skip_q ==
        (5'($past(acc_q)) + 5'($past(insn_word[3:0])) < 5'h10)) else $error("addi skip wrong");
    a_addm_sum: assert property (op == OP_ADDM |=> acc_q ==
        4'($past(acc_q) + $past(mem_nibble)) && !skip_q) else $error("addm sum wrong");
    a_addm_carry: assert property (op == OP_ADDM |=> $stable(cy_q))
        else $error("addm changed carry");
    a_addmc_sum: assert property (op == OP_ADDMC |=> {cy_q, acc_q} ==
        5'($past(acc_q)) + 5'($past(mem_nibble)) + 5'($past(cy_q))) else $error("addmc wrong");
    a_andm_res: assert property (op == OP_ANDM |=> acc_q ==
        ($past(acc_q) & $past(mem_nibble)) && $stable(cy_q) && !skip_q) else $error("and wrong");
    a_decode_exact: assert property (insn_valid && insn_word[9:4] != OP_ADD_IMM
        && insn_word != OP_ADD_MEM && insn_word != OP_ADD_MEMC && insn_word != OP_AND_MEM
        |=> $stable(acc_q) && $stable(cy_q) && !skip_q) else $error("stray decode");

    c_addi_skip:  cover property (op == OP_ADDI ##1 skip_q);
    c_addi_ovf:   cover property (op == OP_ADDI ##1 !skip_q);
    c_addmc_cy:   cover property (op == OP_ADDMC ##1 cy_q);
    c_andm:       cover property (op == OP_ANDM);
    c_addm:       cover property (op == OP_ADDM);

    // skip is a one-cycle pulse owned by add-immediate alone
    a_skip_pulse: assert property (op != OP_ADDI |=> !skip_q)
        else $error("skip without add-immediate");

    a_addmc_noskip: assert property (op == OP_ADDMC |=> !skip_q)
        else $error("addmc asked a skip");

    // an idle cycle must not touch the accumulator or the flag
    a_idle_hold: assert property (!insn_valid |=>
        $stable(acc_q) && $stable(cy_q) && !skip_q)
        else $error("idle cycle changed state");

    a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |=> accumulator == ACC_RESET && carry_flag == CARRY_RESET && !skip_next)
        else $error("reset state wrong");

endmodule : acc_alu

// file: verif/test_accumulator_add_and_logic.sv
// bench for the accumulator add and logic slice
// assumes results show one cycle after the instruction edge
`timescale 1ns/10ps
module test_accumulator_add_and_logic;
    import acc_alu_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       insn_valid = 1'b0;
    logic [9:0] insn_word = 10'h000;
    logic [3:0] mem_nibble = 4'h0;
    logic [3:0] accumulator;
    logic       carry_flag;
    logic       skip_next;
    logic [3:0] acc_m = 4'h0;
    logic       cy_m = 1'b0;
    logic       sk_m = 1'b0;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    acc_alu dut (.sys_clk(sys_clk), .rst_n(rst_n), .insn_valid(insn_valid),
        .insn_word(insn_word), .mem_nibble(mem_nibble), .accumulator(accumulator),
        .carry_flag(carry_flag), .skip_next(skip_next));
    always #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk
    task automatic look;
        chk("accumulator", acc_m, accumulator);
        chk("carry_flag", {3'h0, cy_m}, {3'h0, carry_flag});
        chk("skip_next", {3'h0, sk_m}, {3'h0, skip_next});
    endtask : look
    // unknown codes must leave the model accumulator and carry untouched, so no default branch
    task automatic predict(input logic v, input logic [9:0] w, input logic [3:0] m);
        logic [4:0] s;
        sk_m = 1'b0;
        s = {1'b0, acc_m} + {1'b0, w[3:0]};
        if (v && w[9:4] == 6'h06) begin
            acc_m = s[3:0];
            sk_m = ~s[4];
        end else if (v && w == 10'h00A) acc_m = acc_m + m;
        else if (v && w == 10'h00B) {cy_m, acc_m} = {1'b0, acc_m} + {1'b0, m} + cy_m;
        else if (v && w == 10'h018) acc_m = acc_m & m;
    endtask : predict
    task automatic exec(input logic v, input logic [9:0] w, input logic [3:0] m);
        @(posedge sys_clk);
        insn_valid <= v;
        insn_word <= w;
        mem_nibble <= m;
        predict(v, w, m);
        @(posedge sys_clk);
        insn_valid <= 1'b0;
        #1 look();
    endtask : exec
    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_mem;
        logic [13:0] seq [7] = '{14'h00B_F, 14'h00B_1, 14'h00A_F, 14'h00A_3,
            14'h00B_5, 14'h00B_F, 14'h018_5};
        foreach (seq[i]) exec(1'b1, seq[i][13:4], seq[i][3:0]);
    endtask : t_mem
    task automatic t_addi;
        for (int n = 0; n < 16; n++) exec(1'b1, {6'h06, 4'(n)}, 4'(~n));
    endtask : t_addi
    task automatic t_refuse;
        logic [9:0] bad [7] = '{10'h00C, 10'h01A, 10'h098, 10'h0E5, 10'h265, 10'h10A, 10'h3FF};
        foreach (bad[i]) exec(1'b1, bad[i], 4'hF);
        exec(1'b0, 10'h00B, 4'hF);
    endtask : t_refuse
    // back to back: the skip pulse must drop when the next one is not add-immediate
    task automatic t_b2b;
        @(posedge sys_clk);
        insn_valid <= 1'b1;
        insn_word <= 10'h060;
        predict(1'b1, 10'h060, 4'h0);
        @(posedge sys_clk);
        insn_word <= 10'h00A;
        mem_nibble <= 4'h9;
        #1 look();
        predict(1'b1, 10'h00A, 4'h9);
        @(posedge sys_clk);
        insn_valid <= 1'b0;
        #1 look();
    endtask : t_b2b
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 look();
        t_mem();
        t_addi();
        t_refuse();
        t_b2b();
        test_done();
    end
endmodule : test_accumulator_add_and_logic
